// *** core/drke_params.svh ***
// Purpose: Offsets, field positions, reset values and decode steps.
// Assumes: Register offsets are word indices; byte address is index * 4.
// Notes:   Levels are carried as attenuation in quarter-dB units.
`ifndef DRKE_PARAMS_SVH
`define DRKE_PARAMS_SVH

`define DRKE_IDX_COMP_KNEE   12'h443
`define DRKE_IDX_GATE_KNEE   12'h444
`define DRKE_IDX_EQ_GAINS1   12'h480
`define DRKE_IDX_EQ_GAINS2   12'h481
`define DRKE_IDX_B1_COEFF_A  12'h482
`define DRKE_IDX_B1_COEFF_B  12'h483
`define DRKE_IDX_B1_COEFF_PG 12'h484
`define DRKE_IDX_B2_COEFF_A  12'h485
`define DRKE_IDX_B1_COEFF_C  12'h494
`define DRKE_IDX_DRC_CTRL    12'h4a0

`define DRKE_KNEE_IP_LSB     5
`define DRKE_KNEE_OP_LSB     0
`define DRKE_KNEE2_IP_LSB    5
`define DRKE_KNEE2_OP_LSB    0
`define DRKE_B1_GAIN_LSB     11
`define DRKE_B2_GAIN_LSB     6
`define DRKE_B3_GAIN_LSB     1
`define DRKE_B4_GAIN_LSB     11
`define DRKE_B5_GAIN_LSB     6
`define DRKE_EQ_ENA_BIT      0
`define DRKE_EQ_MODE_BIT     0
`define DRKE_NG_ENA_BIT      0
`define DRKE_KNEE2_OP_EN_BIT 1

`define DRKE_MASK_COMP_KNEE  16'h07ff
`define DRKE_MASK_GATE_KNEE  16'h03ff
`define DRKE_MASK_EQ_GAINS1  16'hffff
`define DRKE_MASK_EQ_GAINS2  16'hffc1
`define DRKE_MASK_DRC_CTRL   16'h0003

`define DRKE_RST_COMP_KNEE   16'h0000
`define DRKE_RST_GATE_KNEE   16'h0000
`define DRKE_RST_EQ_GAINS1   16'h6318
`define DRKE_RST_EQ_GAINS2   16'h6300
`define DRKE_RST_B1_COEFF_A  16'h0fca
`define DRKE_RST_B1_COEFF_B  16'h0400
`define DRKE_RST_B1_COEFF_PG 16'h00d8
`define DRKE_RST_B2_COEFF_A  16'h1eb5
`define DRKE_RST_B1_COEFF_C  16'h0000
`define DRKE_RST_DRC_CTRL    16'h0000

`define DRKE_KNEE_IP_MAX     6'h3c
`define DRKE_KNEE_OP_MAX     5'h1e
`define DRKE_COMP_STEP_QDB   9'd3
`define DRKE_GATE_STEP_QDB   9'd6
`define DRKE_GATE_IN_BASE    9'd144
`define DRKE_GATE_OUT_BASE   9'd120
`define DRKE_GAIN_ZERO_CODE  6'sd12
`define DRKE_GAIN_MAX_CODE   5'h18

`endif

// *** core/drke_pkg.sv ***
// Purpose: Types shared by the knee and equaliser configuration block.
// Assumes: Constants live in drke_params.svh.
// Notes:   Attenuation is unsigned quarter-dB below 0dB.
package drke_pkg;
  typedef enum logic {DRKE_SHELVING, DRKE_PEAKING} drke_shape_e;
  typedef logic [15:0]        drke_word_t;
  typedef logic [8:0]         drke_qdb_t;
  typedef logic signed [5:0]  drke_gain_t;
endpackage

// *** core/drke_lvl_if.sv ***
// Purpose: Raw level fields out to the decoder and decoded values back.
// Assumes: One clock domain; purely combinational carrier.
// Notes:   Five gain lanes, band one first.
`timescale 1ns/1ns
interface drke_lvl_if;
  logic [5:0]          comp_in_code;
  logic [4:0]          comp_out_code;
  logic [4:0]          gate_in_code;
  logic [4:0]          gate_out_code;
  logic [4:0]          gain_code [5];
  drke_pkg::drke_qdb_t comp_in_qdb;
  drke_pkg::drke_qdb_t comp_out_qdb;
  drke_pkg::drke_qdb_t gate_in_qdb;
  drke_pkg::drke_qdb_t gate_out_qdb;
  logic                comp_in_rsvd;
  logic                comp_out_rsvd;
  drke_pkg::drke_gain_t gain_db [5];
  modport regs (output comp_in_code, comp_out_code, gate_in_code,
                gate_out_code, gain_code,
                input comp_in_qdb, comp_out_qdb, gate_in_qdb,
                gate_out_qdb, comp_in_rsvd, comp_out_rsvd, gain_db);
  modport dec (input comp_in_code, comp_out_code, gate_in_code,
               gate_out_code, gain_code,
               output comp_in_qdb, comp_out_qdb, gate_in_qdb,
               gate_out_qdb, comp_in_rsvd, comp_out_rsvd, gain_db);
endinterface

// *** core/drke_level_decode.sv ***
// Purpose: Turns knee and gain codes into quarter-dB and whole-dB values.
// Assumes: Codes come straight from the register file.
// Notes:   Reserved codes flag and saturate at the last legal level.
`timescale 1ns/1ns
`include "drke_params.svh"
module drke_level_decode (
  drke_lvl_if.dec lvl
);
  logic [5:0] comp_in_sat;
  logic [4:0] comp_out_sat;

  assign lvl.comp_in_rsvd  = lvl.comp_in_code > `DRKE_KNEE_IP_MAX;
  assign lvl.comp_out_rsvd = lvl.comp_out_code > `DRKE_KNEE_OP_MAX;
  assign comp_in_sat  = lvl.comp_in_rsvd ? `DRKE_KNEE_IP_MAX
                                         : lvl.comp_in_code;
  assign comp_out_sat = lvl.comp_out_rsvd ? `DRKE_KNEE_OP_MAX
                                          : lvl.comp_out_code;
  assign lvl.comp_in_qdb  = {3'h0, comp_in_sat} * `DRKE_COMP_STEP_QDB;
  assign lvl.comp_out_qdb = {4'h0, comp_out_sat}
                            * `DRKE_COMP_STEP_QDB;
  assign lvl.gate_in_qdb  = `DRKE_GATE_IN_BASE
                            + {4'h0, lvl.gate_in_code}
                            * `DRKE_GATE_STEP_QDB;
  assign lvl.gate_out_qdb = `DRKE_GATE_OUT_BASE
                            + {4'h0, lvl.gate_out_code}
                            * `DRKE_GATE_STEP_QDB;

  // Codes past +12dB are clamped rather than wrapped.
  for (genvar b = 0; b < 5; b++) begin : g_gain
    logic [4:0] code_sat;
    assign code_sat = (lvl.gain_code[b] > `DRKE_GAIN_MAX_CODE)
                      ? `DRKE_GAIN_MAX_CODE : lvl.gain_code[b];
    assign lvl.gain_db[b] = $signed({1'b0, code_sat})
                            - `DRKE_GAIN_ZERO_CODE;
  end
endmodule // drke_level_decode

// *** core/drke_regs.sv ***
// Purpose: Knee-point and playback equaliser configuration behind APB.
// Assumes: APB3 master; byte address is the register index times four.
// Notes:   One wait state on every access; decoded levels are registered.
//
// What this block does
// - Knee input: 0dB down 0.75dB per code to -45dB; higher codes reserved.
// - Compressor knee output: 0dB down 0.75dB per code; 11111 reserved.
// - Gate knee input: -36dB down 1.5dB per code to -82.5dB.
// - Gate knee input level takes effect only while noise gate enabled.
// - Gate knee output: -30dB down 1.5dB per code to -76.5dB.
// - Gate knee output level takes effect only while its enable is set.
// - Five 5-bit band gains, -12dB to +12dB in 1dB, reset 01100.
// - Equaliser in playback path when enable set, bypassed when clear.
// - Band one A, B, PG and band two A coefficients with reset values.
// - Band one coefficient C, 16 bits, resets to zero.
`timescale 1ns/1ns
`include "drke_params.svh"
module drke_regs #(
  parameter int ADDR_W   = 16,
  parameter int SAMPLE_W = 24
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_W-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [SAMPLE_W-1:0]   playback_in,
  input  wire logic [SAMPLE_W-1:0]   eq_return,
  output logic      [SAMPLE_W-1:0]   playback_out,
  output logic                       playback_eq_enable,
  output drke_pkg::drke_shape_e      band_one_shape_select,
  output logic      [29:0]           eq_band_gain_db,
  output logic      [15:0]           band_one_coeff_a,
  output logic      [15:0]           band_one_coeff_b,
  output logic      [15:0]           band_one_coeff_pg,
  output logic      [15:0]           band_one_coeff_c,
  output logic      [15:0]           band_two_coeff_a,
  output logic      [8:0]            comp_knee_in_atten,
  output logic      [8:0]            comp_knee_out_atten,
  output logic                       comp_knee_in_reserved,
  output logic                       comp_knee_out_reserved,
  output logic      [8:0]            gate_knee_in_atten,
  output logic      [8:0]            gate_knee_out_atten,
  output logic                       gate_knee_in_active,
  output logic                       gate_knee_out_active
);
  localparam int NCOEF = 5;

  drke_pkg::drke_word_t comp_knee;
  drke_pkg::drke_word_t gate_knee;
  drke_pkg::drke_word_t eq_gains1;
  drke_pkg::drke_word_t eq_gains2;
  drke_pkg::drke_word_t drc_ctrl;
  drke_pkg::drke_word_t coeff_mem [NCOEF];
  // Reset loads come from constants so the async reset branch stays static.
  localparam drke_pkg::drke_word_t COEFF_RST [NCOEF] = '{
    `DRKE_RST_B1_COEFF_A, `DRKE_RST_B1_COEFF_B, `DRKE_RST_B1_COEFF_PG,
    `DRKE_RST_B2_COEFF_A, `DRKE_RST_B1_COEFF_C
  };

  drke_lvl_if lvl ();

  // Bus decode.
  logic [ADDR_W-3:0]    word_idx;
  logic                 aligned;
  logic                 hit_comp;
  logic                 hit_gate;
  logic                 hit_gains1;
  logic                 hit_gains2;
  logic                 hit_ctrl;
  logic                 hit_coeff;
  logic [2:0]           coeff_sel;
  logic                 mapped;
  logic                 set_ready;
  logic                 access_done;
  logic                 wr_en;
  drke_pkg::drke_word_t wdata16;
  drke_pkg::drke_word_t rd_word;
  logic [31:0]          next_prdata;
  logic                 next_pslverr;

  assign word_idx   = paddr[ADDR_W-1:2];
  assign aligned    = paddr[1:0] == 2'b00;
  assign hit_comp   = aligned && word_idx == `DRKE_IDX_COMP_KNEE;
  assign hit_gate   = aligned && word_idx == `DRKE_IDX_GATE_KNEE;
  assign hit_gains1 = aligned && word_idx == `DRKE_IDX_EQ_GAINS1;
  assign hit_gains2 = aligned && word_idx == `DRKE_IDX_EQ_GAINS2;
  assign hit_ctrl   = aligned && word_idx == `DRKE_IDX_DRC_CTRL;

  // Coefficient slots map onto the storage array by index.
  always_comb begin
    coeff_sel = 3'd0;
    hit_coeff = 1'b0;
    if (!aligned) begin
      hit_coeff = 1'b0;
    end else if (word_idx == `DRKE_IDX_B1_COEFF_A) begin
      coeff_sel = 3'd0;
      hit_coeff = 1'b1;
    end else if (word_idx == `DRKE_IDX_B1_COEFF_B) begin
      coeff_sel = 3'd1;
      hit_coeff = 1'b1;
    end else if (word_idx == `DRKE_IDX_B1_COEFF_PG) begin
      coeff_sel = 3'd2;
      hit_coeff = 1'b1;
    end else if (word_idx == `DRKE_IDX_B2_COEFF_A) begin
      coeff_sel = 3'd3;
      hit_coeff = 1'b1;
    end else if (word_idx == `DRKE_IDX_B1_COEFF_C) begin
      coeff_sel = 3'd4;
      hit_coeff = 1'b1;
    end
  end

  assign mapped = hit_comp | hit_gate | hit_gains1 | hit_gains2
                | hit_ctrl | hit_coeff;

  // The answer comes one cycle into the access phase.
  assign set_ready   = psel & penable & ~pready;
  assign access_done = psel & penable & pready;
  assign wr_en       = access_done & pwrite & mapped;
  assign wdata16     = pwdata[15:0];

  always_comb begin
    rd_word = 16'h0000;
    if (hit_comp) begin
      rd_word = comp_knee;
    end else if (hit_gate) begin
      rd_word = gate_knee;
    end else if (hit_gains1) begin
      rd_word = eq_gains1;
    end else if (hit_gains2) begin
      rd_word = eq_gains2;
    end else if (hit_ctrl) begin
      rd_word = drc_ctrl;
    end else if (hit_coeff) begin
      rd_word = coeff_mem[coeff_sel];
    end
  end

  assign next_prdata  = (!pwrite && mapped) ? {16'h0000, rd_word}
                                            : 32'h0000_0000;
  assign next_pslverr = ~mapped;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= set_ready;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (set_ready) begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Register file; bits without a field are masked so they read zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comp_knee <= `DRKE_RST_COMP_KNEE;
    end else if (wr_en && hit_comp) begin
      comp_knee <= wdata16 & `DRKE_MASK_COMP_KNEE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_knee <= `DRKE_RST_GATE_KNEE;
    end else if (wr_en && hit_gate) begin
      gate_knee <= wdata16 & `DRKE_MASK_GATE_KNEE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eq_gains1 <= `DRKE_RST_EQ_GAINS1;
    end else if (wr_en && hit_gains1) begin
      eq_gains1 <= wdata16 & `DRKE_MASK_EQ_GAINS1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eq_gains2 <= `DRKE_RST_EQ_GAINS2;
    end else if (wr_en && hit_gains2) begin
      eq_gains2 <= wdata16 & `DRKE_MASK_EQ_GAINS2;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drc_ctrl <= `DRKE_RST_DRC_CTRL;
    end else if (wr_en && hit_ctrl) begin
      drc_ctrl <= wdata16 & `DRKE_MASK_DRC_CTRL;
    end
  end

  for (genvar c = 0; c < NCOEF; c++) begin : g_coeff
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        coeff_mem[c] <= COEFF_RST[c];
      end else if (wr_en && hit_coeff && coeff_sel == 3'(c)) begin
        coeff_mem[c] <= wdata16;
      end
    end
  end

  assign band_one_coeff_a  = coeff_mem[0];
  assign band_one_coeff_b  = coeff_mem[1];
  assign band_one_coeff_pg = coeff_mem[2];
  assign band_two_coeff_a  = coeff_mem[3];
  assign band_one_coeff_c  = coeff_mem[4];

  // Level fields out to the decoder.
  assign lvl.comp_in_code  = comp_knee[`DRKE_KNEE_IP_LSB +: 6];
  assign lvl.comp_out_code = comp_knee[`DRKE_KNEE_OP_LSB +: 5];
  assign lvl.gate_in_code  = gate_knee[`DRKE_KNEE2_IP_LSB +: 5];
  assign lvl.gate_out_code = gate_knee[`DRKE_KNEE2_OP_LSB +: 5];
  assign lvl.gain_code[0]  = eq_gains1[`DRKE_B1_GAIN_LSB +: 5];
  assign lvl.gain_code[1]  = eq_gains1[`DRKE_B2_GAIN_LSB +: 5];
  assign lvl.gain_code[2]  = eq_gains1[`DRKE_B3_GAIN_LSB +: 5];
  assign lvl.gain_code[3]  = eq_gains2[`DRKE_B4_GAIN_LSB +: 5];
  assign lvl.gain_code[4]  = eq_gains2[`DRKE_B5_GAIN_LSB +: 5];

  drke_level_decode u_decode (
    .lvl (lvl.dec)
  );

  // Decoded and gated values, registered before leaving the block.
  logic                  noise_gate_enable;
  logic                  gate_knee_output_enable;
  logic                  eq_on;
  drke_pkg::drke_shape_e next_shape;
  logic [8:0]            next_gate_in;
  logic [8:0]            next_gate_out;
  logic [29:0]           next_gain_db;
  logic [SAMPLE_W-1:0]   next_playback;

  assign noise_gate_enable       = drc_ctrl[`DRKE_NG_ENA_BIT];
  assign gate_knee_output_enable = drc_ctrl[`DRKE_KNEE2_OP_EN_BIT];
  assign eq_on = eq_gains1[`DRKE_EQ_ENA_BIT];
  assign next_shape = eq_gains2[`DRKE_EQ_MODE_BIT]
                      ? drke_pkg::DRKE_PEAKING
                      : drke_pkg::DRKE_SHELVING;
  assign next_gate_in  = noise_gate_enable ? lvl.gate_in_qdb
                                           : 9'h000;
  assign next_gate_out = gate_knee_output_enable ? lvl.gate_out_qdb
                                                 : 9'h000;
  assign next_playback = eq_on ? eq_return : playback_in;

  for (genvar b = 0; b < 5; b++) begin : g_gain_pack
    assign next_gain_db[6*b +: 6] = lvl.gain_db[b];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comp_knee_in_atten     <= 9'h000;
      comp_knee_out_atten    <= 9'h000;
      comp_knee_in_reserved  <= 1'b0;
      comp_knee_out_reserved <= 1'b0;
    end else begin
      comp_knee_in_atten     <= lvl.comp_in_qdb;
      comp_knee_out_atten    <= lvl.comp_out_qdb;
      comp_knee_in_reserved  <= lvl.comp_in_rsvd;
      comp_knee_out_reserved <= lvl.comp_out_rsvd;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_knee_in_atten   <= 9'h000;
      gate_knee_out_atten  <= 9'h000;
      gate_knee_in_active  <= 1'b0;
      gate_knee_out_active <= 1'b0;
    end else begin
      gate_knee_in_atten   <= next_gate_in;
      gate_knee_out_atten  <= next_gate_out;
      gate_knee_in_active  <= noise_gate_enable;
      gate_knee_out_active <= gate_knee_output_enable;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      eq_band_gain_db       <= 30'h0000_0000;
      band_one_shape_select <= drke_pkg::DRKE_SHELVING;
      playback_eq_enable    <= 1'b0;
      playback_out          <= '0;
    end else begin
      eq_band_gain_db       <= next_gain_db;
      band_one_shape_select <= next_shape;
      playback_eq_enable    <= eq_on;
      playback_out          <= next_playback;
    end
  end

endmodule // drke_regs

// *** verif/drke_regs_monitor.sv ***
// Purpose: Port-level checks for the knee and equaliser register block.
// Assumes: One clock domain; reset asynchronous, active high.
// Notes:   Bound onto drke_regs from the testbench top file.
`timescale 1ns/1ns
module drke_regs_monitor #(
  parameter int SAMPLE_W = 24
) (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [SAMPLE_W-1:0] playback_in,
  input wire logic [SAMPLE_W-1:0] eq_return,
  input wire logic [SAMPLE_W-1:0] playback_out,
  input wire logic                playback_eq_enable,
  input wire logic [29:0]         eq_band_gain_db,
  input wire logic [8:0]          comp_knee_in_atten,
  input wire logic [8:0]          comp_knee_out_atten,
  input wire logic                comp_knee_in_reserved,
  input wire logic                comp_knee_out_reserved,
  input wire logic [8:0]          gate_knee_in_atten,
  input wire logic [8:0]          gate_knee_out_atten,
  input wire logic                gate_knee_in_active,
  input wire logic                gate_knee_out_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // True when every band gain lies within plus and minus twelve dB.
  function automatic logic gains_ok(input logic [29:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if ($signed(v[i*6 +: 6]) > 6'sd12 || $signed(v[i*6 +: 6]) < -6'sd12)
        ok = 1'b0;
    end
    return ok;
  endfunction

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready high longer than one cycle");
  ready_wait_a: assert property ((psel && !penable) ##1 (psel && penable)
    |-> !pready ##1 pready) else $error("wait state count wrong");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error answer carries data");
  comp_in_map_a: assert property (comp_knee_in_reserved ?
    comp_knee_in_atten == 9'd180 : (comp_knee_in_atten % 3 == 0 &&
    comp_knee_in_atten <= 9'd180)) else $error("knee input level wrong");
  comp_out_map_a: assert property (comp_knee_out_reserved ?
    comp_knee_out_atten == 9'd90 : (comp_knee_out_atten % 3 == 0 &&
    comp_knee_out_atten <= 9'd90)) else $error("knee output level wrong");
  gate_in_map_a: assert property (gate_knee_in_active ?
    (gate_knee_in_atten >= 9'd144 && gate_knee_in_atten <= 9'd330 &&
    gate_knee_in_atten % 6 == 0) : gate_knee_in_atten == 9'd0)
    else $error("gate input level wrong");
  gate_out_map_a: assert property (gate_knee_out_active ?
    (gate_knee_out_atten >= 9'd120 && gate_knee_out_atten <= 9'd306 &&
    gate_knee_out_atten % 6 == 0) : gate_knee_out_atten == 9'd0)
    else $error("gate output level wrong");
  eq_path_a: assert property (playback_eq_enable &&
    $past(playback_eq_enable) && !$past(rst)
    |-> playback_out == $past(eq_return)) else $error("eq path wrong");
  eq_bypass_a: assert property (!playback_eq_enable &&
    !$past(playback_eq_enable) && !$past(rst)
    |-> playback_out == $past(playback_in)) else $error("bypass wrong");
  gain_span_a: assert property (gains_ok(eq_band_gain_db))
    else $error("band gain out of span");

  cover property (pready && pslverr);
  cover property (comp_knee_in_reserved && comp_knee_out_reserved);
  cover property (gate_knee_in_active && gate_knee_out_active);
  cover property (playback_eq_enable);
endmodule // drke_regs_monitor

// *** verif/test_drc_knee_and_playback_eq_config.sv ***
// Purpose: Register and decode tests for the knee and equaliser block.
// Assumes: APB master with one transfer at a time; 125 MHz clock.
// Notes:   Derived outputs are read two edges after a write completes.
`timescale 1ns/1ns
module test_drc_knee_and_playback_eq_config;
  logic                  sys_clk     = 1'b0;
  logic                  rst         = 1'b1;
  logic                  psel        = 1'b0;
  logic                  penable     = 1'b0;
  logic                  pwrite      = 1'b0;
  logic [15:0]           paddr       = 16'h0;
  logic [31:0]           pwdata      = 32'h0;
  logic [23:0]           playback_in = 24'h0;
  logic [23:0]           eq_return   = 24'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [23:0]           playback_out;
  logic                  eq_en;
  drke_pkg::drke_shape_e shape;
  logic [29:0]           gain_db;
  logic [15:0]           cf [5];
  logic [8:0]            ci_att, co_att, gi_att, go_att;
  logic                  ci_rsv, co_rsv, gi_act, go_act;
  logic [31:0]           rd;
  logic                  er;
  int                    err_total = 0;
  int                    checked   = 0;
  logic [15:0] ra [10] = '{16'h110c, 16'h1110, 16'h1200, 16'h1204, 16'h1208,
                           16'h120c, 16'h1210, 16'h1214, 16'h1250, 16'h1280};
  logic [15:0] rv [10] = '{16'h0, 16'h0, 16'h6318, 16'h6300, 16'h0fca,
                           16'h0400, 16'h00d8, 16'h1eb5, 16'h0, 16'h0};
  int kip [5] = '{0, 1, 60, 61, 63};
  int kop [5] = '{0, 1, 30, 31, 31};

  always #4 sys_clk = ~sys_clk;

  drke_regs DUT (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .playback_in(playback_in),
    .eq_return(eq_return), .playback_out(playback_out),
    .playback_eq_enable(eq_en), .band_one_shape_select(shape),
    .eq_band_gain_db(gain_db), .band_one_coeff_a(cf[0]),
    .band_one_coeff_b(cf[1]), .band_one_coeff_pg(cf[2]),
    .band_two_coeff_a(cf[3]), .band_one_coeff_c(cf[4]),
    .comp_knee_in_atten(ci_att), .comp_knee_out_atten(co_att),
    .comp_knee_in_reserved(ci_rsv), .comp_knee_out_reserved(co_rsv),
    .gate_knee_in_atten(gi_att), .gate_knee_out_atten(go_att),
    .gate_knee_in_active(gi_act), .gate_knee_out_active(go_act)
  );

  task automatic end_sim();
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask

  // Entered just after a rising edge; leaves one edge after the answer.
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20)
      err_total++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("gain_db_rst", gain_db, 32'h0);
    chk("shape_rst", shape, drke_pkg::DRKE_SHELVING);
    chk("eq_en_rst", eq_en, 32'h0);
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, ra[i], 32'h0);
      chk("reset_value", rd, rv[i]);
      chk("read_ok", er, 32'h0);
    end
    for (int i = 4; i < 9; i++) begin
      xfer(1'b1, ra[i], 32'hffff_a55a ^ i);
      chk("write_data", rd, 32'h0);
      chk("write_ok", er, 32'h0);
    end
    for (int i = 4; i < 9; i++) begin
      xfer(1'b0, ra[i], 32'h0);
      chk("coeff_read", rd, 32'ha55a ^ i);
      chk("coeff_port", cf[i-4], 32'ha55a ^ i);
    end
    xfer(1'b0, 16'h1300, 32'h0);
    chk("unmapped_err", er, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    xfer(1'b1, 16'h1201, 32'h0);
    chk("misaligned_err", er, 32'h1);
    xfer(1'b0, 16'h1200, 32'h0);
    chk("gains_kept", rd, 32'h6318);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 16'h110c, {21'h0, kip[i][5:0], kop[i][4:0]});
      @(posedge sys_clk);
      chk("knee_in", ci_att, (kip[i] > 60 ? 60 : kip[i]) * 3);
      chk("knee_in_rsv", ci_rsv, kip[i] > 60);
      chk("knee_out", co_att, (kop[i] > 30 ? 30 : kop[i]) * 3);
      chk("knee_out_rsv", co_rsv, kop[i] > 30);
    end
    xfer(1'b1, 16'h1110, {22'h0, 5'd31, 5'd5});
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 16'h1280, c);
      @(posedge sys_clk);
      chk("gate_in", gi_att, c[0] ? 330 : 0);
      chk("gate_out", go_att, c[1] ? 150 : 0);
      chk("gate_in_act", gi_act, c[0]);
      chk("gate_out_act", go_act, c[1]);
    end
    xfer(1'b1, 16'h1110, 32'h0);
    @(posedge sys_clk);
    chk("gate_in_base", gi_att, 32'd144);
    chk("gate_out_base", go_att, 32'd120);
    xfer(1'b1, 16'h1110, 32'hffff);
    xfer(1'b0, 16'h1110, 32'h0);
    chk("gate_mask", rd, 32'h03ff);
    xfer(1'b1, 16'h1200, 32'h063f);
    xfer(1'b1, 16'h1204, 32'h6ac1);
    @(posedge sys_clk);
    chk("gain_db", gain_db, {6'h3f, 6'h01, 6'h0c, 6'h0c, 6'h34});
    chk("shape", shape, drke_pkg::DRKE_PEAKING);
    chk("eq_en", eq_en, 32'h1);
    playback_in <= 24'h123456;
    eq_return   <= 24'h654321;
    repeat (2) @(posedge sys_clk);
    chk("path_eq", playback_out, 32'h654321);
    xfer(1'b1, 16'h1200, 32'h063e);
    repeat (2) @(posedge sys_clk);
    chk("path_bypass", playback_out, 32'h123456);
    end_sim();
  end

  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule // test_drc_knee_and_playback_eq_config

bind drke_regs drke_regs_monitor #(.SAMPLE_W(SAMPLE_W)) mon (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .playback_in(playback_in), .eq_return(eq_return),
  .playback_out(playback_out), .playback_eq_enable(playback_eq_enable),
  .eq_band_gain_db(eq_band_gain_db),
  .comp_knee_in_atten(comp_knee_in_atten),
  .comp_knee_out_atten(comp_knee_out_atten),
  .comp_knee_in_reserved(comp_knee_in_reserved),
  .comp_knee_out_reserved(comp_knee_out_reserved),
  .gate_knee_in_atten(gate_knee_in_atten),
  .gate_knee_out_atten(gate_knee_out_atten),
  .gate_knee_in_active(gate_knee_in_active),
  .gate_knee_out_active(gate_knee_out_active)
);
